// ==== core/wict_top.v ====
// Wake input pull/filter configuration and cyclic timer one
// Overview of operation
// - Pull register top bits read zero
// - Third input pull in bits 5:4
// - Second input pull in bits 3:2
// - First input pull in bits 1:0
// - Filter register fields, top bits zero
// - Code 00: static, 16us filter
// - Code 01: static, 64us filter
// - Code 10: cyclic, sampled at timer one
// - Code 11: cyclic, sampled at timer two
// - On-time 000 stops timer, output low
// - On-time codes 0.1 to 20 ms
// - Code 110 stops timer, output high
// - Period codes 10 ms to 2 s
// - Timer starts once on-time written
// - Restart clear also clears timer fields when any input uses a cyclic filter code
// - Cyclic sense and wake run together
// - Registers clear on reset
// - Wake enable gates timer expiry wake
//
// Usage notes
// The host reaches the three registers through the serial decoder, one byte
// per write strobe; read data appear one clock after the address settles.
// Reserved bits are masked on the way in, so they always read back as zero.
// Soft reset is synchronous and level sensitive; it clears only the three
// configuration registers and leaves the filters and pin synchronisers running.
// Timer one counts in 0.1 ms ticks. The tick divider is held while the
// timer is stopped, so the first on-window after a start is a full tick
// long instead of a random fraction of one.
// Changing the on-time between two running codes keeps the current cycle;
// only the compare limit moves. A stop code ends the cycle at once.
// Reserved on-time code 111 behaves like a stop with the output low, and
// reserved period code 111 falls back to the shortest period, so a host
// error never leaves a switch stuck high.
// Cyclic filter codes need a timer assigned to a switch by the host; with
// no on-time end events the filtered level simply keeps its last value.
// The restart clear of timer one beats a host write in the same cycle, so a
// write racing the clear is lost and must be repeated after restart.
// Wake pulses are one clock long and come only while the wake enable is set;
// cyclic sensing and cyclic wake share the same on-time end event.
`timescale 1ns/10ps
`include "wict_defines.vh"
module wict_top #(
  parameter TICK_CYC = `WICT_TICK_CYC,
  parameter SHORT_CYC = `WICT_FLT_SHORT_CYC,
  parameter LONG_CYC = `WICT_FLT_LONG_CYC
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register access from the serial interface decoder
  input wire [`WICT_ADDR_W-1:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_reg,
  // Device state
  input wire soft_reset,
  input wire chip_restart_state,
  input wire high_side_clear,
  input wire timer_one_wake_enable,
  input wire cyclic_timer_two_on_end,
  // Wake pins
  input wire wake_input_first,
  input wire wake_input_second,
  input wire wake_input_third,
  // Outputs
  output reg [5:0] pull_select_reg,
  output reg [2:0] wake_level_reg,
  output reg timer_one_out_reg,
  output reg timer_one_wake_reg
);
  // Timer states: stopped with a static level, on-window, off remainder
  localparam ST_STOP = 2'h0;
  localparam ST_ON = 2'h1;
  localparam ST_OFF = 2'h2;

  // Configuration registers, stored with reserved bits forced low
  reg [7:0] wake_pull_config;
  reg [7:0] wake_filter_config;
  reg [7:0] cyclic_timer_one_control;
  // Pin synchronisers
  reg [2:0] pin_meta_reg;
  reg [2:0] pin_sync_reg;
  // Timer one state and time base
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] tick_cnt_reg;
  reg [14:0] ms_cnt_reg;
  reg [14:0] ms_cnt_next;
  reg t1_on_end_reg;
  // Decoded fields and time-base strobe
  wire [2:0] filt_level;
  wire [2:0] on_code = cyclic_timer_one_control[`WICT_ON_MSB:`WICT_ON_LSB];
  wire [2:0] per_code = cyclic_timer_one_control[`WICT_PER_MSB:0];
  wire tick = (tick_cnt_reg == TICK_CYC[15:0] - 16'h0001);
  wire cyclic_active = wake_filter_config[1] | wake_filter_config[3] | wake_filter_config[5];

  // On-time in 0.1 ms ticks; 111 reserved, treated as stopped
  function [14:0] on_ticks;
    input [2:0] code;
    begin
      case (code)
        3'h1: on_ticks = 15'd1;
        3'h2: on_ticks = 15'd3;
        3'h3: on_ticks = 15'd10;
        3'h4: on_ticks = 15'd100;
        3'h5: on_ticks = 15'd200;
        default: on_ticks = 15'd0;
      endcase
    end
  endfunction

  // Period in 0.1 ms ticks; 111 reserved, falls back to 10 ms
  function [14:0] per_ticks;
    input [2:0] code;
    begin
      case (code)
        3'h1: per_ticks = 15'd200;
        3'h2: per_ticks = 15'd500;
        3'h3: per_ticks = 15'd1000;
        3'h4: per_ticks = 15'd2000;
        3'h5: per_ticks = 15'd10000;
        3'h6: per_ticks = 15'd20000;
        default: per_ticks = 15'd100;
      endcase
    end
  endfunction

  // True for on-time codes that run the timer
  function running_code;
    input [2:0] code;
    begin
      running_code = (code != `WICT_ON_LOW) && (code != `WICT_ON_HIGH) && (code != 3'h7);
    end
  endfunction

  // Register writes; reserved bits masked so they never store
  // Soft reset outranks every write in the same cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wake_pull_config <= `WICT_RST_VAL;
      wake_filter_config <= `WICT_RST_VAL;
      cyclic_timer_one_control <= `WICT_RST_VAL;
    end else if (soft_reset) begin
      wake_pull_config <= `WICT_RST_VAL;
      wake_filter_config <= `WICT_RST_VAL;
      cyclic_timer_one_control <= `WICT_RST_VAL;
    end else begin
      if (reg_wr && reg_addr == `WICT_ADDR_PULL) begin
        wake_pull_config <= reg_wdata & `WICT_PULL_MASK;
      end
      if (reg_wr && reg_addr == `WICT_ADDR_FILT) begin
        wake_filter_config <= reg_wdata & `WICT_FILT_MASK;
      end
      // Restart clear of switches with cyclic sense wipes timer too
      if (chip_restart_state && high_side_clear && cyclic_active) begin
        cyclic_timer_one_control <= `WICT_RST_VAL;
      end else if (reg_wr && reg_addr == `WICT_ADDR_TMR1) begin
        cyclic_timer_one_control <= reg_wdata & `WICT_TMR_MASK;
      end
    end
  end

  // Read mux, registered; unmapped addresses read zero
  // Reading has no side effects, so the address may be left parked
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_reg <= 8'h00;
    end else begin
      case (reg_addr)
        `WICT_ADDR_PULL: reg_rdata_reg <= wake_pull_config;
        `WICT_ADDR_FILT: reg_rdata_reg <= wake_filter_config;
        `WICT_ADDR_TMR1: reg_rdata_reg <= cyclic_timer_one_control;
        default: reg_rdata_reg <= 8'h00;
      endcase
    end
  end

  // Two-stage synchroniser for the asynchronous wake pins
  // Only the second stage is read by the filters
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {wake_input_third, wake_input_second, wake_input_first};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // 0.1 ms time base; held while stopped so the first on-window is a full tick
  // A tick ends each 0.1 ms; periods stay aligned because ticks run while running
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg <= 16'h0000;
    end else if (tick || state_reg == ST_STOP) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // Timer state machine
  always @* begin
    state_next = state_reg;
    ms_cnt_next = ms_cnt_reg;
    case (state_reg)
      // Stopped: counter cleared, waits for a running code
      ST_STOP: begin
        ms_cnt_next = 15'd0;
        if (running_code(on_code)) begin
          state_next = ST_ON;
        end
      end
      // On-window: counts ticks up to the selected on-time
      ST_ON: begin
        if (!running_code(on_code)) begin
          state_next = ST_STOP;
        end else if (tick) begin
          ms_cnt_next = ms_cnt_reg + 15'd1;
          if (ms_cnt_reg + 15'd1 >= on_ticks(on_code)) begin
            state_next = ST_OFF;
          end
        end
      end
      // Off remainder: same counter runs on to the full period
      ST_OFF: begin
        if (!running_code(on_code)) begin
          state_next = ST_STOP;
        end else if (tick) begin
          ms_cnt_next = ms_cnt_reg + 15'd1;
          if (ms_cnt_reg + 15'd1 >= per_ticks(per_code)) begin
            state_next = ST_ON;
            ms_cnt_next = 15'd0;
          end
        end
      end
      default: begin
        state_next = ST_STOP;
        ms_cnt_next = 15'd0;
      end
    endcase
  end

  // Timer registers and outputs
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_STOP;
      ms_cnt_reg <= 15'd0;
      t1_on_end_reg <= 1'b0;
      timer_one_out_reg <= 1'b0;
      timer_one_wake_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ms_cnt_reg <= ms_cnt_next;
      // On-time end strobe feeds the cyclic filters a cycle later
      t1_on_end_reg <= (state_reg == ST_ON) && (state_next == ST_OFF);
      // Stopped codes set a static level for the assigned switches
      if (state_next == ST_STOP) begin
        timer_one_out_reg <= (on_code == `WICT_ON_HIGH);
      end else begin
        timer_one_out_reg <= (state_next == ST_ON);
      end
      // Wake pulse per expiry, independent of cyclic sensing use
      timer_one_wake_reg <= timer_one_wake_enable && (state_reg == ST_ON) &&
        (state_next == ST_OFF);
    end
  end

  // Pull selections and filtered wake levels go out registered
  // Registering adds one cycle of latency to pull and level outputs
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pull_select_reg <= 6'h00;
      wake_level_reg <= 3'h0;
    end else begin
      pull_select_reg <= wake_pull_config[5:0];
      wake_level_reg <= filt_level;
    end
  end

  // One filter per wake input; host keeps timers assigned for cyclic codes
  // The filters share the on-time end strobes; timer two lives elsewhere
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_filt
      wict_wake_filter #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
      ) u_filt (
        .clk(clk),
        .nrst(nrst),
        .mode(wake_filter_config[2*gi+1:2*gi]),
        .pin_sync(pin_sync_reg[gi]),
        .t1_on_end(t1_on_end_reg),
        .t2_on_end(cyclic_timer_two_on_end),
        .level_reg(filt_level[gi])
      );
    end
  endgenerate
endmodule // wict_top

// ==== inc/wict_defines.vh ====
// Constants for the wake input and cyclic timer configuration block
`ifndef WICT_DEFINES_VH
`define WICT_DEFINES_VH
`define WICT_ADDR_W 7
`define WICT_ADDR_PULL 7'h08
`define WICT_ADDR_FILT 7'h09
`define WICT_ADDR_TMR1 7'h0c
`define WICT_RST_VAL 8'h00
`define WICT_PULL_MASK 8'h3f
`define WICT_FILT_MASK 8'h3f
`define WICT_TMR_MASK 8'h77
`define WICT_ON_LSB 4
`define WICT_ON_MSB 6
`define WICT_PER_MSB 2
`define WICT_ON_LOW 3'h0
`define WICT_ON_HIGH 3'h6
`define WICT_FLT_STAT16 2'h0
`define WICT_FLT_STAT64 2'h1
`define WICT_FLT_CYC_T1 2'h2
`define WICT_FLT_CYC_T2 2'h3
`define WICT_CLK_MHZ 125
`define WICT_TICK_NS 100000
`define WICT_TICK_CYC ((`WICT_TICK_NS * `WICT_CLK_MHZ) / 1000)
`define WICT_FLT_SHORT_US 16
`define WICT_FLT_LONG_US 64
`define WICT_FLT_SHORT_CYC (`WICT_FLT_SHORT_US * `WICT_CLK_MHZ)
`define WICT_FLT_LONG_CYC (`WICT_FLT_LONG_US * `WICT_CLK_MHZ)
`endif

// ==== core/wict_wake_filter.v ====
// Wake input filter: static stability filter or sampled at on-time end
`timescale 1ns/10ps
`include "wict_defines.vh"
module wict_wake_filter #(
  parameter SHORT_CYC = `WICT_FLT_SHORT_CYC,
  parameter LONG_CYC = `WICT_FLT_LONG_CYC
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Configuration and events
  input wire [1:0] mode,
  input wire pin_sync,
  input wire t1_on_end,
  input wire t2_on_end,
  // Result
  output reg level_reg
);
  reg [13:0] cnt_reg;
  reg samp_reg;
  wire cyclic = mode[1];
  wire [13:0] limit = (mode == `WICT_FLT_STAT64) ? LONG_CYC[13:0] : SHORT_CYC[13:0];
  wire sample_end = (mode == `WICT_FLT_CYC_T1) ? t1_on_end : t2_on_end;

  // Static: accept after stable for limit; cyclic: 16us window ends at on-time end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 14'h0000;
      samp_reg <= 1'b0;
      level_reg <= 1'b0;
    end else if (!cyclic) begin
      if (pin_sync == level_reg) begin
        cnt_reg <= 14'h0000;
      end else if (cnt_reg >= limit - 14'h0001) begin
        level_reg <= pin_sync;
        cnt_reg <= 14'h0000;
      end else begin
        cnt_reg <= cnt_reg + 14'h0001;
      end
    end else begin
      // Stability tracked continuously, so last 16us before on-time end counts
      if (pin_sync != samp_reg) begin
        samp_reg <= pin_sync;
        cnt_reg <= 14'h0000;
      end else if (cnt_reg < SHORT_CYC[13:0]) begin
        cnt_reg <= cnt_reg + 14'h0001;
      end
      if (sample_end && cnt_reg >= SHORT_CYC[13:0] - 14'h0001) begin
        level_reg <= samp_reg;
      end
    end
  end
endmodule // wict_wake_filter

// ==== verification/wict_host_model.sv ====
// Host model that drives register writes and reads
`timescale 1ns/10ps
`include "wict_defines.vh"
module wict_host_model (
  // Clock
  input wire clk,
  // Register bus
  output reg [`WICT_ADDR_W-1:0] reg_addr,
  output reg reg_wr,
  output reg [7:0] reg_wdata,
  input wire [7:0] reg_rdata_reg
);
  // Idle on an unmapped address
  initial begin
    reg_addr = 7'h7f;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // One-cycle strobe; data is inverted after so stale bytes never look valid
  task wr(input [6:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
    end
  endtask
  // Read data lands one edge after the address
  task rd(input [6:0] a, output [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      @(posedge clk);
      @(negedge clk);
      d = reg_rdata_reg;
    end
  endtask
endmodule // wict_host_model

// ==== verification/wict_top_assertions.sv ====
// Port checks for the wake input and cyclic timer block
`timescale 1ns/10ps
`include "wict_defines.vh"
module wict_top_assertions #(
  parameter TICK_CYC = `WICT_TICK_CYC
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register bus
  input wire [`WICT_ADDR_W-1:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_reg,
  // State and outputs
  input wire soft_reset,
  input wire chip_restart_state,
  input wire timer_one_wake_enable,
  input wire [5:0] pull_select_reg,
  input wire timer_one_out_reg,
  input wire timer_one_wake_reg
);
  localparam int HI_GAP = TICK_CYC - 8;
  reg [2:0] on_reg;
  wire tw = reg_wr && reg_addr == `WICT_ADDR_TMR1 && !soft_reset && !chip_restart_state;
  wire pw = reg_wr && reg_addr == `WICT_ADDR_PULL && !soft_reset;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // On-time shadow; missed restart clears only hide starts, never fake them
  always @(posedge clk or negedge nrst) begin
    if (!nrst) on_reg <= 3'h0;
    else if (soft_reset) on_reg <= 3'h0;
    else if (tw) on_reg <= reg_wdata[6:4];
  end
  sequence s_start;
    tw && reg_wdata[6:4] == 3'h1 && on_reg inside {3'h0, 3'h7};
  endsequence
  sequence s_window;
    timer_one_out_reg [*8] ##HI_GAP timer_one_out_reg ##1 !timer_one_out_reg;
  endsequence
  a_on_window: assert property (s_start |-> ##2 s_window)
    else $error("on window wrong");
  a_pull_mirror: assert property (pw ##1 !(reg_wr || soft_reset) |->
    ##1 {2'h0, pull_select_reg} == ($past(reg_wdata, 2) & `WICT_PULL_MASK))
    else $error("pull copy wrong");
  a_top_zero: assert property (
    $past(reg_addr) inside {`WICT_ADDR_PULL, `WICT_ADDR_FILT} |-> reg_rdata_reg[7:6] == 2'h0)
    else $error("top bits set");
  a_tmr_rsvd: assert property ($past(reg_addr) == `WICT_ADDR_TMR1 |->
    (reg_rdata_reg & ~`WICT_TMR_MASK) == 8'h00) else $error("timer reserved set");
  a_unmapped_zero: assert property (
    !($past(reg_addr) inside {`WICT_ADDR_PULL, `WICT_ADDR_FILT, `WICT_ADDR_TMR1})
    |-> reg_rdata_reg == 8'h00) else $error("unmapped read");
  a_soft_clear: assert property (soft_reset [*3] |->
    ##1 pull_select_reg == 6'h00 && !timer_one_out_reg) else $error("soft clear");
  a_on_low: assert property (tw && reg_wdata[6:4] inside {3'h0, 3'h7} |->
    ##3 !timer_one_out_reg [*4]) else $error("stop low");
  a_on_high: assert property (tw && reg_wdata[6:4] == 3'h6 |->
    ##3 timer_one_out_reg [*8]) else $error("stop high");
  a_wake_gate: assert property (
    !timer_one_wake_enable && !$past(timer_one_wake_enable) |-> !timer_one_wake_reg)
    else $error("wake ungated");
endmodule // wict_top_assertions
bind wict_top wict_top_assertions #(.TICK_CYC(TICK_CYC)) u_chk (.clk(clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg),
  .soft_reset(soft_reset), .chip_restart_state(chip_restart_state),
  .timer_one_wake_enable(timer_one_wake_enable), .pull_select_reg(pull_select_reg),
  .timer_one_out_reg(timer_one_out_reg), .timer_one_wake_reg(timer_one_wake_reg));

// ==== verification/tb_top.sv ====
// Self-checking bench for the wake input and cyclic timer block
`timescale 1ns/10ps
module tb_top;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg srst = 1'b0;
  reg rs = 1'b0;
  reg hc = 1'b0;
  reg we = 1'b0;
  reg t2e = 1'b0;
  reg [2:0] pin = 3'h0;
  wire [6:0] ad;
  wire wr;
  wire [7:0] wd;
  wire [7:0] rd;
  wire [5:0] pull;
  wire [2:0] lvl;
  wire tout;
  wire twk;
  reg [7:0] d;
  integer num_errors = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer n;
  integer w;
  // 125 MHz clock
  always #4 clk = ~clk;
  wict_host_model h (.clk(clk), .reg_addr(ad), .reg_wr(wr), .reg_wdata(wd), .reg_rdata_reg(rd));
  wict_top #(.TICK_CYC(10), .SHORT_CYC(8), .LONG_CYC(32)) dut (.clk(clk), .nrst(nrst),
    .reg_addr(ad), .reg_wr(wr), .reg_wdata(wd), .reg_rdata_reg(rd), .soft_reset(srst),
    .chip_restart_state(rs), .high_side_clear(hc), .timer_one_wake_enable(we),
    .cyclic_timer_two_on_end(t2e), .wake_input_first(pin[0]), .wake_input_second(pin[1]),
    .wake_input_third(pin[2]), .pull_select_reg(pull), .wake_level_reg(lvl),
    .timer_one_out_reg(tout), .timer_one_wake_reg(twk));
  // Hang guard, about four times the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end
  // Compare after the edge has settled
  task chk(input [31:0] nm, input [7:0] s, input [7:0] e);
    begin
      #1;
      n_compared = n_compared + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task rc(input [6:0] a, input [7:0] e);
    begin
      h.rd(a, d);
      chk("reg", d, e);
    end
  endtask
  // Count on cycles and wake pulses
  task run(input integer k);
    begin
      n = 0;
      w = 0;
      repeat (k) begin
        @(posedge clk);
        #1;
        if (tout === 1'b1) n = n + 1;
        if (twk === 1'b1) w = w + 1;
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rc(7'h08, 8'h00);
    rc(7'h09, 8'h00);
    rc(7'h0c, 8'h00);
    h.wr(7'h08, 8'hff);
    rc(7'h08, 8'h3f);
    h.wr(7'h08, 8'h1b);
    rc(7'h08, 8'h1b);
    chk("pull", pull, 8'h1b);
    h.wr(7'h0b, 8'hff);
    rc(7'h0b, 8'h00);
    h.wr(7'h09, 8'hff);
    rc(7'h09, 8'h3f);
    h.wr(7'h0c, 8'hff);
    rc(7'h0c, 8'h77);
    $display("test registers done");
    h.wr(7'h09, 8'h04);
    @(posedge clk) pin <= 3'h3;
    repeat (6) @(posedge clk);
    chk("lvl", lvl, 8'h00);
    repeat (8) @(posedge clk);
    chk("lvl", lvl, 8'h01);
    repeat (26) @(posedge clk);
    chk("lvl", lvl, 8'h03);
    @(posedge clk) pin <= 3'h2;
    repeat (4) @(posedge clk);
    pin <= 3'h3;
    repeat (12) @(posedge clk);
    chk("lvl", lvl, 8'h03);
    $display("test static filter done");
    @(posedge clk) we <= 1'b1;
    h.wr(7'h0c, 8'h10);
    run(1100);
    chk("on", n[7:0], 8'h14);
    chk("wake", w[7:0], 8'h02);
    @(posedge clk) we <= 1'b0;
    run(1000);
    chk("wake", w[7:0], 8'h00);
    h.wr(7'h0c, 8'h60);
    repeat (4) @(posedge clk);
    run(16);
    chk("on", n[7:0], 8'h10);
    h.wr(7'h0c, 8'h00);
    repeat (4) @(posedge clk);
    run(16);
    chk("on", n[7:0], 8'h00);
    $display("test timer done");
    h.wr(7'h09, 8'h2c);
    @(posedge clk) pin <= 3'h7;
    repeat (30) @(posedge clk);
    chk("lvl", lvl, 8'h03);
    @(posedge clk) we <= 1'b1;
    h.wr(7'h0c, 8'h10);
    run(20);
    chk("lvl", lvl, 8'h07);
    chk("wake", w[7:0], 8'h01);
    @(posedge clk) pin <= 3'h5;
    repeat (20) @(posedge clk);
    chk("lvl", lvl, 8'h07);
    @(posedge clk) t2e <= 1'b1;
    @(posedge clk) t2e <= 1'b0;
    repeat (4) @(posedge clk);
    chk("lvl", lvl, 8'h05);
    $display("test cyclic filter done");
    @(posedge clk) rs <= 1'b1;
    hc <= 1'b1;
    repeat (3) @(posedge clk);
    rs <= 1'b0;
    hc <= 1'b0;
    rc(7'h0c, 8'h00);
    @(posedge clk) srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rc(7'h08, 8'h00);
    rc(7'h09, 8'h00);
    $display("test clears done");
    tally_and_finish;
  end
endmodule // tb_top
